// ===== common/cmpc_link_if.sv
// Carrier between the hysteresis decision and the synchroniser/edge detector.
// Assumes both sides run in the system clock domain except the raw level.
`timescale 1ns/1ps
interface cmpc_link_if;
    logic raw;      // Unsynchronised comparator decision.
    logic latched;  // Raw result after the two-flop synchroniser.
    logic rise;     // One-cycle pulse on a latched 0-to-1 change.
    logic fall;     // One-cycle pulse on a latched 1-to-0 change.

    modport decide (output raw);
    modport track  (input raw, output latched, output rise, output fall);
    modport use_it (input raw, input latched, input rise, input fall);
endinterface : cmpc_link_if

// ===== common/cmpc_pkg.sv
// Constants, register layout and helpers for the comparator digital control block.
// Assumes an 8-bit special function register bus with a page selector and a 50 MHz system clock.
package cmpc_pkg;

    // Bus and register addresses.
    localparam logic [3:0] CMPC_PAGE_MAIN     = 4'h0;
    localparam logic [7:0] CMPC_ADDR_CONTROL  = 8'h9b;
    localparam logic [7:0] CMPC_ADDR_MODE     = 8'h9d;

    // Control register field positions.
    localparam int CMPC_CTL_EN_BIT    = 7;
    localparam int CMPC_CTL_OUT_BIT   = 6;
    localparam int CMPC_CTL_RIF_BIT   = 5;
    localparam int CMPC_CTL_FIF_BIT   = 4;
    localparam int CMPC_CTL_HYP_LSB   = 2;
    localparam int CMPC_CTL_HYN_LSB   = 0;

    // Mode register field positions and fixed bits.
    localparam int CMPC_MD_RIE_BIT    = 5;
    localparam int CMPC_MD_FIE_BIT    = 4;
    localparam int CMPC_MD_RESV_BIT   = 7;
    localparam int CMPC_MD_MODE_LSB   = 0;

    // Reset values.
    localparam logic [7:0] CMPC_CTL_RESET      = 8'h00;
    localparam logic [1:0] CMPC_MODE_RESET     = 2'h2;
    localparam logic [7:0] CMPC_UNMAPPED_READ  = 8'h00;

    // Analog input representation and hysteresis levels in millivolts.
    localparam int CMPC_MV_W = 12;
    localparam logic [CMPC_MV_W:0] CMPC_HYST_MV_1 = 13'h005;
    localparam logic [CMPC_MV_W:0] CMPC_HYST_MV_2 = 13'h00a;
    localparam logic [CMPC_MV_W:0] CMPC_HYST_MV_3 = 13'h014;

    // Maps a two-bit hysteresis selector to its level in millivolts.
    function automatic logic [CMPC_MV_W:0] cmpc_hyst_mv(input logic [1:0] sel);
        case (sel)
            2'h1:    cmpc_hyst_mv = CMPC_HYST_MV_1;
            2'h2:    cmpc_hyst_mv = CMPC_HYST_MV_2;
            2'h3:    cmpc_hyst_mv = CMPC_HYST_MV_3;
            default: cmpc_hyst_mv = 13'h000;
        endcase
    endfunction : cmpc_hyst_mv

endpackage : cmpc_pkg

// ===== src/cmpc_edge.sv
// Synchroniser for the raw comparator result and edge detector on its output.
// Assumes the raw level may change at any time relative to the system clock.
`timescale 1ns/1ps
module cmpc_edge (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Raw in, latched and edges out.
    cmpc_link_if.track link
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // Two flops for the asynchronous level, then one more to remember the previous value.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= link.raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edges compare the latched output with its value one clock earlier.
    assign link.latched = sync_q;
    assign link.rise    = sync_q & ~prev_q;
    assign link.fall    = ~sync_q & prev_q;
endmodule : cmpc_edge

// ===== src/cmpc_hyst.sv
// Digital decision of the comparator with selectable hysteresis.
// Assumes input voltages arrive as millivolt codes from the analog core.
`timescale 1ns/1ps
module cmpc_hyst
    import cmpc_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // Configuration.
    input  wire logic                 enable_i,
    input  wire logic [1:0]           hyp_sel_i,
    input  wire logic [1:0]           hyn_sel_i,
    // Analog levels.
    input  wire logic [CMPC_MV_W-1:0] pos_mv_i,
    input  wire logic [CMPC_MV_W-1:0] neg_mv_i,
    // Raw result.
    cmpc_link_if.decide               link
);
    logic              state_q;
    logic [CMPC_MV_W:0] pos_ext;
    logic [CMPC_MV_W:0] neg_ext;
    logic               above;
    logic               below;

    // Threshold tests; each band edge moves by its own hysteresis.
    assign pos_ext = {1'b0, pos_mv_i};
    assign neg_ext = {1'b0, neg_mv_i};
    assign above   = pos_ext > (neg_ext + cmpc_hyst_mv(hyp_sel_i));
    assign below   = (pos_ext + cmpc_hyst_mv(hyn_sel_i)) < neg_ext;

    // The decision is combinational so it stays valid with the clock stopped; inside the band it holds.
    assign link.raw = enable_i & (above | (~below & state_q));

    // The held state only matters inside the band, so one clock of lag is harmless.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= 1'b0;
        end else begin
            state_q <= link.raw;
        end
    end
endmodule : cmpc_hyst

// ===== src/cmpc_top.sv
// Comparator digital control: registers, enable, hysteresis, synchroniser, edge flags and interrupt.
// Assumes a synchronous 8-bit register bus with page select and an analog core giving millivolt codes.
`timescale 1ns/1ps
module cmpc_top
    import cmpc_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk_sys_i,
    input  wire logic                 resetn_i,
    // Register bus.
    input  wire logic [3:0]           sfr_page_i,
    input  wire logic [7:0]           sfr_addr_i,
    input  wire logic                 sfr_wr_i,
    input  wire logic                 sfr_rd_i,
    input  wire logic [7:0]           sfr_wdata_i,
    output logic      [7:0]           sfr_rdata_o,
    output logic                      sfr_rvalid_o,
    // Analog core.
    input  wire logic [CMPC_MV_W-1:0] positive_compare_input_i,
    input  wire logic [CMPC_MV_W-1:0] negative_compare_input_i,
    output logic                      comparator_enable_o,
    output logic      [1:0]           response_time_mode_o,
    output logic      [1:0]           positive_hysteresis_select_o,
    output logic      [1:0]           negative_hysteresis_select_o,
    // Outputs and interrupt.
    output logic                      raw_compare_output_o,
    output logic                      latched_compare_output_o,
    input  wire logic                 irq_source_enable_i,
    input  wire logic                 global_irq_enable_i,
    output logic                      irq_o
);
    // Reset release synchroniser.
    logic rst_meta_q;
    logic rst_n_q;

    // Register state.
    logic       enable_q;
    logic       enable_d;
    logic [1:0] hyp_q;
    logic [1:0] hyp_d;
    logic [1:0] hyn_q;
    logic [1:0] hyn_d;
    logic       rise_flag_q;
    logic       rise_flag_d;
    logic       fall_flag_q;
    logic       fall_flag_d;
    logic       rise_ie_q;
    logic       rise_ie_d;
    logic       fall_ie_q;
    logic       fall_ie_d;
    logic [1:0] mode_q;
    logic [1:0] mode_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rvalid_q;

    // Decode and read mux.
    wire        page_hit;
    wire        hit_control;
    wire        hit_mode;
    wire        wr_control;
    wire        wr_mode;
    wire [7:0]  control_view;
    wire [7:0]  mode_view;

    cmpc_link_if link ();

    // The whole design leaves reset on a clean edge, while entering it asynchronously.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Address decode on the fixed page.
    assign page_hit    = (sfr_page_i == CMPC_PAGE_MAIN);
    assign hit_control = page_hit && (sfr_addr_i == CMPC_ADDR_CONTROL);
    assign hit_mode    = page_hit && (sfr_addr_i == CMPC_ADDR_MODE);
    assign wr_control  = sfr_wr_i && hit_control;
    assign wr_mode     = sfr_wr_i && hit_mode;

    // Register views; reserved mode bit 7 reads one and unused bits read zero.
    assign control_view = {enable_q, link.latched, rise_flag_q, fall_flag_q, hyp_q, hyn_q};
    assign mode_view    = {1'b1, 1'b0, rise_ie_q, fall_ie_q, 2'b00, mode_q};

    // Next state of the control fields.
    assign enable_d = wr_control ? sfr_wdata_i[CMPC_CTL_EN_BIT] : enable_q;
    assign hyp_d    = wr_control ? sfr_wdata_i[CMPC_CTL_HYP_LSB +: 2] : hyp_q;
    assign hyn_d    = wr_control ? sfr_wdata_i[CMPC_CTL_HYN_LSB +: 2] : hyn_q;

    // A detected edge beats a coincident software write, so no event is lost.
    assign rise_flag_d = link.rise ? 1'b1 : (wr_control ? sfr_wdata_i[CMPC_CTL_RIF_BIT] : rise_flag_q);
    assign fall_flag_d = link.fall ? 1'b1 : (wr_control ? sfr_wdata_i[CMPC_CTL_FIF_BIT] : fall_flag_q);

    // Next state of the mode fields.
    assign rise_ie_d = wr_mode ? sfr_wdata_i[CMPC_MD_RIE_BIT] : rise_ie_q;
    assign fall_ie_d = wr_mode ? sfr_wdata_i[CMPC_MD_FIE_BIT] : fall_ie_q;
    assign mode_d    = wr_mode ? sfr_wdata_i[CMPC_MD_MODE_LSB +: 2] : mode_q;

    // Read data is captured on the strobe; unmapped addresses answer zero.
    assign rdata_d = !sfr_rd_i   ? rdata_q :
                     hit_control ? control_view :
                     hit_mode    ? mode_view : CMPC_UNMAPPED_READ;

    // Control register.
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            enable_q    <= CMPC_CTL_RESET[CMPC_CTL_EN_BIT];
            hyp_q       <= CMPC_CTL_RESET[CMPC_CTL_HYP_LSB +: 2];
            hyn_q       <= CMPC_CTL_RESET[CMPC_CTL_HYN_LSB +: 2];
            rise_flag_q <= CMPC_CTL_RESET[CMPC_CTL_RIF_BIT];
            fall_flag_q <= CMPC_CTL_RESET[CMPC_CTL_FIF_BIT];
        end else begin
            enable_q    <= enable_d;
            hyp_q       <= hyp_d;
            hyn_q       <= hyn_d;
            rise_flag_q <= rise_flag_d;
            fall_flag_q <= fall_flag_d;
        end
    end

    // Mode register and read port.
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rise_ie_q <= 1'b0;
            fall_ie_q <= 1'b0;
            mode_q    <= CMPC_MODE_RESET;
            rdata_q   <= CMPC_UNMAPPED_READ;
            rvalid_q  <= 1'b0;
        end else begin
            rise_ie_q <= rise_ie_d;
            fall_ie_q <= fall_ie_d;
            mode_q    <= mode_d;
            rdata_q   <= rdata_d;
            rvalid_q  <= sfr_rd_i;
        end
    end

    // Raw decision with hysteresis.
    cmpc_hyst u_hyst (
        .clk_i     (clk_sys_i),
        .rst_n_i   (rst_n_q),
        .enable_i  (enable_q),
        .hyp_sel_i (hyp_q),
        .hyn_sel_i (hyn_q),
        .pos_mv_i  (positive_compare_input_i),
        .neg_mv_i  (negative_compare_input_i),
        .link      (link)
    );

    // Synchroniser and edge detector.
    cmpc_edge u_edge (
        .clk_i   (clk_sys_i),
        .rst_n_i (rst_n_q),
        .link    (link)
    );

    // Outputs to the analog core and the pins; the core shuts down while the enable is low.
    assign comparator_enable_o          = enable_q;
    assign response_time_mode_o         = mode_q;
    assign positive_hysteresis_select_o = hyp_q;
    assign negative_hysteresis_select_o = hyn_q;
    assign raw_compare_output_o         = link.raw;
    assign latched_compare_output_o     = link.latched;
    assign sfr_rdata_o                  = rdata_q;
    assign sfr_rvalid_o                 = rvalid_q;

    // Interrupt needs a flag with its enable, plus both outer enables.
    assign irq_o = ((rise_flag_q & rise_ie_q) | (fall_flag_q & fall_ie_q))
                   & irq_source_enable_i & global_irq_enable_i;

    // Cycles since reset release, so checks do not look back into reset.
    logic [1:0] age_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_q);

    property p_off_low;
        !enable_q |-> !link.raw;
    endproperty
    a_off_low: assert property (p_off_low) else $error("Raw output high while disabled.");

    property p_above_high;
        enable_q && ({1'b0, positive_compare_input_i} >
            ({1'b0, negative_compare_input_i} + cmpc_hyst_mv(hyp_q))) |-> link.raw;
    endproperty
    a_above_high: assert property (p_above_high) else $error("Raw output low above threshold.");

    property p_pos_hyst;
        (age_q == 2'h3) && !$past(link.raw) && ({1'b0, positive_compare_input_i} <=
            ({1'b0, negative_compare_input_i} + cmpc_hyst_mv(hyp_q))) |-> !link.raw;
    endproperty
    a_pos_hyst: assert property (p_pos_hyst) else $error("Output rose inside positive hysteresis.");

    property p_neg_hyst;
        (age_q == 2'h3) && enable_q && $past(link.raw) && (({1'b0, positive_compare_input_i}
            + cmpc_hyst_mv(hyn_q)) >= {1'b0, negative_compare_input_i}) |-> link.raw;
    endproperty
    a_neg_hyst: assert property (p_neg_hyst) else $error("Output fell inside negative hysteresis.");

    property p_sync_delay;
        (age_q == 2'h3) |-> link.latched == $past(link.raw, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("Latched output is not raw delayed by two.");

    property p_read_out;
        sfr_rd_i && hit_control |=> sfr_rvalid_o && sfr_rdata_o[CMPC_CTL_OUT_BIT] == $past(link.latched);
    endproperty
    a_read_out: assert property (p_read_out) else $error("Output bit read does not match latched output.");

    property p_rise_set;
        $rose(link.latched) |=> rise_flag_q;
    endproperty
    a_rise_set: assert property (p_rise_set) else $error("Rising edge did not set its flag.");

    property p_fall_set;
        $fell(link.latched) |=> fall_flag_q;
    endproperty
    a_fall_set: assert property (p_fall_set) else $error("Falling edge did not set its flag.");

    property p_sticky;
        fall_flag_q && !wr_control |=> fall_flag_q;
    endproperty
    a_sticky: assert property (p_sticky) else $error("Falling flag cleared without a write.");

    property p_irq;
        irq_o |-> irq_source_enable_i && global_irq_enable_i
                  && ((rise_flag_q && rise_ie_q) || (fall_flag_q && fall_ie_q));
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt raised without a qualified flag.");

    property p_enable_write;
        wr_control |=> comparator_enable_o == $past(sfr_wdata_i[CMPC_CTL_EN_BIT]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("Enable bit did not follow write.");

    property p_mode_write;
        wr_mode |=> response_time_mode_o == $past(sfr_wdata_i[1:0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("Response mode did not follow write.");

    property p_set_wins;
        link.rise && wr_control && !sfr_wdata_i[CMPC_CTL_RIF_BIT] |=> rise_flag_q;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Clear beat a coincident rising edge.");

    c_rise: cover property (link.rise ##1 rise_flag_q);
    c_fall: cover property (link.fall ##1 fall_flag_q);
    c_irq: cover property ($rose(irq_o));
    c_set_clear: cover property (link.rise && wr_control && !sfr_wdata_i[CMPC_CTL_RIF_BIT]);
endmodule : cmpc_top

// ===== verif/cmpc_analog_model.sv
// Behavioural analog comparator core: presents requested input levels to the block.
// Assumes the bench sets target levels; slower response modes delay their arrival.
`timescale 1ns/1ps
module cmpc_analog_model
    import cmpc_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // Settings from the block.
    input  wire logic [1:0]           mode_i,
    // Requested and presented levels.
    input  wire logic [CMPC_MV_W-1:0] pos_req_i,
    input  wire logic [CMPC_MV_W-1:0] neg_req_i,
    output logic      [CMPC_MV_W-1:0] pos_mv_o,
    output logic      [CMPC_MV_W-1:0] neg_mv_o
);
    logic [2:0] wait_q;

    // A new level settles after mode plus one cycles, so mode 3 answers slowest.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_mv_o <= 12'h000;
            neg_mv_o <= 12'h000;
            wait_q   <= 3'h0;
        end else if (pos_req_i != pos_mv_o || neg_req_i != neg_mv_o) begin
            if (wait_q >= {1'b0, mode_i}) begin
                pos_mv_o <= pos_req_i;
                neg_mv_o <= neg_req_i;
                wait_q   <= 3'h0;
            end else begin
                wait_q <= wait_q + 3'h1;
            end
        end
    end
endmodule : cmpc_analog_model

// ===== verif/tb.sv
// Self-checking bench for the comparator control block through its register bus.
// Assumes the analog model in cmpc_analog_model and a 50 MHz system clock.
`timescale 1ns/1ps
module tb;
    import cmpc_pkg::*;
    logic                 clk, rst_n, wr, rd, src_en, glb_en, en, raw, lat, irq, rvalid;
    logic [3:0]           page;
    logic [7:0]           addr, wdata, rdata, d;
    logic [1:0]           rmode, hyp, hyn;
    logic [CMPC_MV_W-1:0] pos_req, neg_req, pos_mv, neg_mv;
    int                   n_fail, n_compared;
    int                   lvl [3] = '{5, 10, 20};

    cmpc_top dut_u (.clk_sys_i(clk), .resetn_i(rst_n), .sfr_page_i(page), .sfr_addr_i(addr),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid),
        .positive_compare_input_i(pos_mv), .negative_compare_input_i(neg_mv), .comparator_enable_o(en),
        .response_time_mode_o(rmode), .positive_hysteresis_select_o(hyp),
        .negative_hysteresis_select_o(hyn), .raw_compare_output_o(raw), .latched_compare_output_o(lat),
        .irq_source_enable_i(src_en), .global_irq_enable_i(glb_en), .irq_o(irq));

    cmpc_analog_model ana_u (.clk_i(clk), .rst_n_i(rst_n), .mode_i(rmode), .pos_req_i(pos_req),
        .neg_req_i(neg_req), .pos_mv_o(pos_mv), .neg_mv_o(neg_mv));

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the verdict and ends the run.
    task automatic final_report();
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    // One-cycle write strobe; the value is in effect after the taking edge.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1 wr = 1'b1; addr = a; wdata = v;
        @(posedge clk);
        #1 wr = 1'b0;
    endtask : wr_reg

    // One-cycle read strobe; data and valid are looked at in the answer cycle.
    task automatic rd_reg(input logic [3:0] p, input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1 rd = 1'b1; addr = a; page = p;
        @(posedge clk);
        #1 rd = 1'b0;
        page = 4'h0;
        v = rdata;
        check({7'h00, rvalid}, 8'h01);
    endtask : rd_reg

    // Waits a bounded time for the latched output to reach a level.
    task automatic wait_lat(input logic e);
        for (int i = 0; i < 20 && lat !== e; i++) begin
            @(posedge clk);
            #1;
        end
        check({7'h00, lat}, {7'h00, e});
        repeat (2) @(posedge clk);
        #1;
    endtask : wait_lat

    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        #400us;
        n_fail++;
        final_report();
    end

    // Main sequence.
    initial begin
        n_fail = 0; n_compared = 0;
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; page = 4'h0; addr = 8'h00; wdata = 8'h00;
        src_en = 1'b1; glb_en = 1'b1; pos_req = 12'd1500; neg_req = 12'd1000;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(4'h0, CMPC_ADDR_CONTROL, d); check(d, 8'h00);
        rd_reg(4'h0, CMPC_ADDR_MODE, d); check(d, 8'h82);
        rd_reg(4'h1, CMPC_ADDR_CONTROL, d); check(d, 8'h00);
        rd_reg(4'h0, 8'h9c, d); check(d, 8'h00);
        check({7'h00, raw}, 8'h00);
        check({7'h00, lat}, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr_reg(CMPC_ADDR_MODE, 8'h80 | m[7:0]);
            check({6'h00, rmode}, m[7:0]);
            rd_reg(4'h0, CMPC_ADDR_MODE, d); check(d, 8'h80 | m[7:0]);
        end
        for (int h = 0; h < 4; h++) begin
            wr_reg(CMPC_ADDR_CONTROL, {4'h0, h[1:0], ~h[1:0]});
            check({4'h0, hyp, hyn}, {4'h0, h[1:0], ~h[1:0]});
            rd_reg(4'h0, CMPC_ADDR_CONTROL, d); check(d, {4'h0, h[1:0], ~h[1:0]});
        end
        wr_reg(CMPC_ADDR_CONTROL, 8'h00);
        repeat (10) @(posedge clk);
        #1;
        check({7'h00, raw}, 8'h00);
        wr_reg(CMPC_ADDR_MODE, 8'hb0);
        wr_reg(CMPC_ADDR_CONTROL, 8'h80);
        check({7'h00, en}, 8'h01);
        wait_lat(1'b1);
        check({7'h00, raw}, 8'h01);
        rd_reg(4'h0, CMPC_ADDR_CONTROL, d); check(d, 8'he0);
        check({7'h00, irq}, 8'h01);
        glb_en = 1'b0;
        #1 check({7'h00, irq}, 8'h00);
        glb_en = 1'b1; src_en = 1'b0;
        #1 check({7'h00, irq}, 8'h00);
        src_en = 1'b1;
        // Only the falling enable is on, yet only the rising flag is set, so no request may appear.
        wr_reg(CMPC_ADDR_MODE, 8'h90);
        check({7'h00, irq}, 8'h00);
        wr_reg(CMPC_ADDR_MODE, 8'hb0);
        repeat (5) @(posedge clk);
        rd_reg(4'h0, CMPC_ADDR_CONTROL, d); check(d, 8'he0);
        wr_reg(CMPC_ADDR_CONTROL, 8'h80);
        rd_reg(4'h0, CMPC_ADDR_CONTROL, d); check(d, 8'hc0);
        check({7'h00, irq}, 8'h00);
        // Each hysteresis level: just at the band edge holds, one millivolt past it switches.
        for (int h = 1; h < 4; h++) begin
            wr_reg(CMPC_ADDR_CONTROL, {4'h8, h[1:0], h[1:0]});
            pos_req = 12'd900;
            wait_lat(1'b0);
            wr_reg(CMPC_ADDR_CONTROL, {4'h8, h[1:0], h[1:0]});
            pos_req = 12'd1000 + lvl[h-1][11:0];
            repeat (10) @(posedge clk);
            #1;
            check({7'h00, raw}, 8'h00);
            pos_req = 12'd1001 + lvl[h-1][11:0];
            wait_lat(1'b1);
            pos_req = 12'd1000 - lvl[h-1][11:0];
            repeat (10) @(posedge clk);
            #1;
            check({7'h00, raw}, 8'h01);
            pos_req = 12'd999 - lvl[h-1][11:0];
            wait_lat(1'b0);
            rd_reg(4'h0, CMPC_ADDR_CONTROL, d); check(d, {4'hb, h[1:0], h[1:0]});
            check({7'h00, irq}, 8'h01);
        end
        // The clearing write is timed to land on the edge at which the rise is seen; the set must win.
        pos_req = 12'd1500;
        repeat (2) @(posedge clk);
        #1;
        wr_reg(CMPC_ADDR_CONTROL, 8'h8f);
        rd_reg(4'h0, CMPC_ADDR_CONTROL, d); check(d, 8'hef);
        wr_reg(CMPC_ADDR_CONTROL, 8'h0f);
        #1 check({7'h00, raw}, 8'h00);
        wait_lat(1'b0);
        rd_reg(4'h0, CMPC_ADDR_CONTROL, d); check(d, 8'h1f);
        final_report();
    end
endmodule : tb
